// ### bfwf_pkg.sv
// package for the blitter flip wait flags block: register map, fields, types
// Function
// - enabled pending flip stalls parser fetch
// - flip completes when active address loaded
// - bit 8 waits on plane C async flip
// - bit 7 waits on plane C sync flip
// - bit 6 waits on sprite C sync flip
// - bit 9 reports sprite C flip pending
// - bits 11,10 plane C async/sync fields
// - condition code wait holds while code active
// - select zero disables, one to five enable
package bfwf_pkg;
    localparam int          ADDR_W         = 4;
    localparam int          DATA_W         = 32;
    localparam int          NFLIP          = 6;
    localparam int          CC_W           = 15;
    localparam int          SEL_W          = 4;
    // register offsets (byte addresses)
    localparam logic [3:0]  OFS_FLAGS      = 4'h0;
    localparam logic [3:0]  OFS_IRQ_STAT   = 4'h4;
    localparam logic [3:0]  OFS_IRQ_MASK   = 4'h8;
    localparam logic [3:0]  OFS_CC         = 4'hc;
    // field positions of the flags register
    localparam int          BIT_CCSEL_LO   = 0;
    localparam int          BIT_RSVD       = 5;
    localparam int          BIT_SPRC_SYNC  = 6;
    localparam int          BIT_PLNC_SYNC  = 7;
    localparam int          BIT_PLNC_ASYNC = 8;
    localparam int          BIT_SPRC_PEND  = 9;
    localparam int          BIT_PLNC_SPEND = 10;
    localparam int          BIT_PLNC_APEND = 11;
    localparam logic [3:0]  CCSEL_OFF      = 4'h0;
    localparam logic [3:0]  CCSEL_MAX      = 4'h5;
    localparam logic [31:0] FLAGS_RESET    = 32'h0000_0000;
    localparam logic [2:0]  IRQ_RESET      = 3'h0;
    // flip source index
    localparam int          FL_PLNC_ASYNC  = 0;
    localparam int          FL_PLNC_SYNC   = 1;
    localparam int          FL_SPRC_SYNC   = 2;
    // interrupt status bits
    localparam int          IRQ_WAIT_START = 0;
    localparam int          IRQ_WAIT_END   = 1;
    localparam int          IRQ_FLIP_DONE  = 2;

    typedef enum logic [1:0] {
        BFWF_RUN  = 2'b01,
        BFWF_WAIT = 2'b10
    } bfwf_state_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } bfwf_bus_t;

    typedef struct packed {
        logic              async_en;
        logic              sync_en;
        logic              spr_en;
        logic [SEL_W-1:0]  cc_sel;
    } bfwf_cfg_t;
endpackage

// ### bfwf_top.sv
// blitter flip wait flags: parser stall on display flips and condition codes
`timescale 1ns/100ps
module bfwf_top
    import bfwf_pkg::*;
(
    // clock and reset
    input  wire logic               mclk,
    input  wire logic               rst_n,
    // register port
    input  wire logic [ADDR_W-1:0]  reg_addr,
    input  wire logic [DATA_W-1:0]  reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [DATA_W-1:0]  reg_rdata,
    // display engine flip status, asynchronous to mclk
    input  wire logic [2:0]         flip_req,
    input  wire logic [2:0]         flip_loaded,
    // condition codes from the parser domain
    input  wire logic [CC_W-1:0]    execute_condition_code_register,
    // parser control
    output logic                    parser_stall,
    output logic                    irq
);

    typedef struct packed {
        bfwf_cfg_t         cfg;
        logic [2:0]        req_s1, req_s2, req_s3;
        logic [2:0]        ld_s1, ld_s2, ld_s3;
        logic [2:0]        req_q, ld_q;
        logic [2:0]        pend;
        bfwf_state_t       state;
        logic [2:0]        irq_stat;
        logic [2:0]        irq_mask;
        logic [DATA_W-1:0] rdata;
        logic              stall;
        logic              irq;
    } bfwf_regs_t;

    bfwf_regs_t r, nx;
    logic [1:0] rst_sync_r;
    logic       srst_n;

    // reset release through two flops; kept out of the state struct
    // because it is cleared by the pin, not by its own output
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign srst_n = rst_sync_r[1];

    // the whole flags register as read back
    function automatic logic [DATA_W-1:0] flags_word(bfwf_cfg_t c, logic [2:0] p);
        logic [DATA_W-1:0] w;
        w                 = '0;
        w[BIT_CCSEL_LO +: SEL_W] = c.cc_sel;
        w[BIT_SPRC_SYNC]  = c.spr_en;
        w[BIT_PLNC_SYNC]  = c.sync_en;
        w[BIT_PLNC_ASYNC] = c.async_en;
        w[BIT_SPRC_PEND]  = p[FL_SPRC_SYNC];
        w[BIT_PLNC_SPEND] = p[FL_PLNC_SYNC];
        w[BIT_PLNC_APEND] = p[FL_PLNC_ASYNC];
        return w;
    endfunction

    logic [2:0] en_vec;
    logic       cc_wait;
    logic       flip_wait;
    logic       want;
    logic [2:0] done_ev;

    always_comb begin
        nx          = r;
        // three-flop sampling; a change counts when s2 and s3 agree
        nx.req_s1   = flip_req;
        nx.req_s2   = r.req_s1;
        nx.req_s3   = r.req_s2;
        nx.ld_s1    = flip_loaded;
        nx.ld_s2    = r.ld_s1;
        nx.ld_s3    = r.ld_s2;
        for (int i = 0; i < 3; i++) begin
            if (r.req_s2[i] == r.req_s3[i]) nx.req_q[i] = r.req_s3[i];
            if (r.ld_s2[i] == r.ld_s3[i])   nx.ld_q[i]  = r.ld_s3[i];
        end
        // pending from request until the new address reaches active regs
        done_ev = r.pend & r.ld_q;
        nx.pend = (r.pend & ~r.ld_q) | (r.req_q & ~r.ld_q);

        en_vec[FL_PLNC_ASYNC] = r.cfg.async_en;
        en_vec[FL_PLNC_SYNC]  = r.cfg.sync_en;
        en_vec[FL_SPRC_SYNC]  = r.cfg.spr_en;
        flip_wait = |(en_vec & r.pend);
        // out-of-range selects above five are treated as disabled
        cc_wait = (r.cfg.cc_sel != CCSEL_OFF) && (r.cfg.cc_sel <= CCSEL_MAX)
                  && execute_condition_code_register[r.cfg.cc_sel - 4'h1];
        want = flip_wait | cc_wait;

        case (r.state)
            BFWF_RUN:  if (want)  nx.state = BFWF_WAIT;
            BFWF_WAIT: if (!want) nx.state = BFWF_RUN;
            default:   nx.state = BFWF_RUN;
        endcase
        nx.stall = want;

        // register writes; bit 5 and the pending bits are not stored
        if (reg_wr && reg_addr == OFS_FLAGS) begin
            nx.cfg.cc_sel   = reg_wdata[BIT_CCSEL_LO +: SEL_W];
            nx.cfg.spr_en   = reg_wdata[BIT_SPRC_SYNC];
            nx.cfg.sync_en  = reg_wdata[BIT_PLNC_SYNC];
            nx.cfg.async_en = reg_wdata[BIT_PLNC_ASYNC];
        end
        if (reg_wr && reg_addr == OFS_IRQ_MASK) nx.irq_mask = reg_wdata[2:0];

        // read data one cycle later; unmapped reads return zero
        nx.rdata = '0;
        if (reg_rd) begin
            case (reg_addr)
                OFS_FLAGS:    nx.rdata = flags_word(r.cfg, r.pend);
                OFS_IRQ_STAT: nx.rdata = {29'h0, r.irq_stat};
                OFS_IRQ_MASK: nx.rdata = {29'h0, r.irq_mask};
                OFS_CC:       nx.rdata = {17'h0, execute_condition_code_register};
                default:      nx.rdata = '0;
            endcase
        end

        // sticky status, read clears, new events win over the clear
        if (reg_rd && reg_addr == OFS_IRQ_STAT) nx.irq_stat = IRQ_RESET;
        if (want && r.state == BFWF_RUN)  nx.irq_stat[IRQ_WAIT_START] = 1'b1;
        if (!want && r.state == BFWF_WAIT) nx.irq_stat[IRQ_WAIT_END] = 1'b1;
        if (|done_ev) nx.irq_stat[IRQ_FLIP_DONE] = 1'b1;
        nx.irq = |(nx.irq_stat & r.irq_mask);
    end

    always_ff @(posedge mclk or negedge srst_n) begin
        if (!srst_n) begin
            r.cfg      <= '0;
            r.req_s1   <= 3'h0;
            r.req_s2   <= 3'h0;
            r.req_s3   <= 3'h0;
            r.ld_s1    <= 3'h0;
            r.ld_s2    <= 3'h0;
            r.ld_s3    <= 3'h0;
            r.req_q    <= 3'h0;
            r.ld_q     <= 3'h0;
            r.pend     <= 3'h0;
            r.state    <= BFWF_RUN;
            r.irq_stat <= IRQ_RESET;
            r.irq_mask <= IRQ_RESET;
            r.rdata    <= FLAGS_RESET;
            r.stall    <= 1'b0;
            r.irq      <= 1'b0;
        end else begin
            r.cfg      <= nx.cfg;
            r.req_s1   <= nx.req_s1;
            r.req_s2   <= nx.req_s2;
            r.req_s3   <= nx.req_s3;
            r.ld_s1    <= nx.ld_s1;
            r.ld_s2    <= nx.ld_s2;
            r.ld_s3    <= nx.ld_s3;
            r.req_q    <= nx.req_q;
            r.ld_q     <= nx.ld_q;
            r.pend     <= nx.pend;
            r.state    <= nx.state;
            r.irq_stat <= nx.irq_stat;
            r.irq_mask <= nx.irq_mask;
            r.rdata    <= nx.rdata;
            r.stall    <= nx.stall;
            r.irq      <= nx.irq;
        end
    end

    assign reg_rdata    = r.rdata;
    assign parser_stall = r.stall;
    assign irq          = r.irq;

    a_stall_on_flip: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.sync_en && r.pend[FL_PLNC_SYNC]) |=> parser_stall)
        else $error("no stall with enabled plane sync flip pending");
    a_async_wait: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.async_en && r.pend[FL_PLNC_ASYNC]) |=> parser_stall)
        else $error("no stall with plane async flip pending");
    a_sprite_wait: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.spr_en && r.pend[FL_SPRC_SYNC]) |=> parser_stall)
        else $error("no stall with sprite flip pending");
    a_pend_clears: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[0] && r.ld_q[0]) |=> !r.pend[0])
        else $error("flip pending kept after active load");
    a_no_cause_run: assert property (@(posedge mclk) disable iff (!srst_n)
        (!flip_wait && !cc_wait) |=> !parser_stall)
        else $error("stall without cause");
    a_sprite_report: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS) |=> reg_rdata[BIT_SPRC_PEND] == $past(r.pend[2]))
        else $error("sprite pending misreported");
    a_plane_report: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[BIT_PLNC_APEND +: 1] == $past(r.pend[0]))
        else $error("plane async pending misreported");
    a_rsvd_zero: assert property (@(posedge mclk) disable iff (!srst_n)
        $past(reg_rd) |-> !reg_rdata[BIT_RSVD])
        else $error("reserved bit read nonzero");
    a_cc_wait: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.cc_sel == 4'h1 && execute_condition_code_register[0]) |=> parser_stall)
        else $error("no stall on active condition code");
    a_cc_off: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.cc_sel == CCSEL_OFF && !flip_wait) |=> !parser_stall)
        else $error("stall with condition wait disabled");

    // stall follows any enabled pending flip or an active selected condition code, and nothing else
    a_flip_stall: assert property (@(posedge mclk) disable iff (!srst_n)
        flip_wait
        |=> parser_stall)
        else $error("no stall with enabled flip pending");

    a_stall_cause: assert property (@(posedge mclk) disable iff (!srst_n)
        parser_stall
        |-> $past(want))
        else $error("stall raised without a wait cause");

    a_no_enables: assert property (@(posedge mclk) disable iff (!srst_n)
        (!r.cfg.async_en && !r.cfg.sync_en && !r.cfg.spr_en)
        |-> !flip_wait)
        else $error("flip wait with every enable clear");

    a_state_stall: assert property (@(posedge mclk) disable iff (!srst_n)
        r.state == (parser_stall ? BFWF_WAIT : BFWF_RUN))
        else $error("wait state and stall output disagree");

    a_state_onehot: assert property (@(posedge mclk) disable iff (!srst_n)
        $onehot(r.state))
        else $error("wait state not one-hot");

    // pending lives from the filtered request until the active load
    a_pend_sync_clr: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[FL_PLNC_SYNC] && r.ld_q[FL_PLNC_SYNC])
        |=> !r.pend[FL_PLNC_SYNC])
        else $error("plane sync pending kept after active load");

    a_pend_spr_clr: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[FL_SPRC_SYNC] && r.ld_q[FL_SPRC_SYNC])
        |=> !r.pend[FL_SPRC_SYNC])
        else $error("sprite pending kept after active load");

    a_pend_async_hold: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[FL_PLNC_ASYNC] && !r.ld_q[FL_PLNC_ASYNC])
        |=> r.pend[FL_PLNC_ASYNC])
        else $error("plane async pending dropped before load");

    a_pend_sync_hold: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[FL_PLNC_SYNC] && !r.ld_q[FL_PLNC_SYNC])
        |=> r.pend[FL_PLNC_SYNC])
        else $error("plane sync pending dropped before load");

    a_pend_spr_hold: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.pend[FL_SPRC_SYNC] && !r.ld_q[FL_SPRC_SYNC])
        |=> r.pend[FL_SPRC_SYNC])
        else $error("sprite pending dropped before load");

    a_pend_needs_req: assert property (@(posedge mclk) disable iff (!srst_n)
        $rose(r.pend[FL_PLNC_ASYNC])
        |-> $past(r.req_q[FL_PLNC_ASYNC]))
        else $error("plane async pending without request");

    a_flip_done_irq: assert property (@(posedge mclk) disable iff (!srst_n)
        (|done_ev)
        |=> r.irq_stat[IRQ_FLIP_DONE])
        else $error("flip completion not recorded");

    // the filter only moves once the second and third flops agree
    a_req_filter: assert property (@(posedge mclk) disable iff (!srst_n)
        $changed(r.req_q)
        |-> $past(r.req_s2 == r.req_s3))
        else $error("request filter moved on disagreement");

    a_ld_filter: assert property (@(posedge mclk) disable iff (!srst_n)
        $changed(r.ld_q)
        |-> $past(r.ld_s2 == r.ld_s3))
        else $error("load filter moved on disagreement");

    // read-back of enables and pending flags
    a_async_en_read: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[BIT_PLNC_ASYNC] == $past(r.cfg.async_en))
        else $error("plane async enable misreported");

    a_sync_en_read: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[BIT_PLNC_SYNC] == $past(r.cfg.sync_en))
        else $error("plane sync enable misreported");

    a_spr_en_read: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[BIT_SPRC_SYNC] == $past(r.cfg.spr_en))
        else $error("sprite enable misreported");

    a_sync_report: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[BIT_PLNC_SPEND] == $past(r.pend[FL_PLNC_SYNC]))
        else $error("plane sync pending misreported");

    a_flags_upper: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_FLAGS)
        |=> reg_rdata[DATA_W-1:BIT_PLNC_APEND+1] == '0)
        else $error("unused flags bits read nonzero");

    a_rdata_idle: assert property (@(posedge mclk) disable iff (!srst_n)
        !reg_rd
        |=> reg_rdata == '0)
        else $error("read data outside its cycle");

    // condition code wait: select range and release
    a_cc_sel_high: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.cc_sel > CCSEL_MAX)
        |-> !cc_wait)
        else $error("condition wait on a select above range");

    a_cc_top_sel: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.cc_sel == CCSEL_MAX
            && execute_condition_code_register[CCSEL_MAX - 4'h1])
        |=> parser_stall)
        else $error("no stall on highest selected code");

    a_cc_release: assert property (@(posedge mclk) disable iff (!srst_n)
        (r.cfg.cc_sel != CCSEL_OFF && r.cfg.cc_sel <= CCSEL_MAX && !flip_wait
            && !execute_condition_code_register[r.cfg.cc_sel - 4'h1])
        |=> !parser_stall)
        else $error("stall kept after selected code cleared");

    a_cc_mirror: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_CC)
        |=> reg_rdata[CC_W-1:0] == $past(execute_condition_code_register))
        else $error("condition code mirror misreported");

    // interrupt status and level
    a_wait_start: assert property (@(posedge mclk) disable iff (!srst_n)
        (want && r.state == BFWF_RUN)
        |=> r.irq_stat[IRQ_WAIT_START])
        else $error("stall start not recorded");

    a_wait_end: assert property (@(posedge mclk) disable iff (!srst_n)
        (!want && r.state == BFWF_WAIT)
        |=> r.irq_stat[IRQ_WAIT_END])
        else $error("stall end not recorded");

    a_irq_level: assert property (@(posedge mclk) disable iff (!srst_n)
        irq == |(r.irq_stat & $past(r.irq_mask)))
        else $error("irq level disagrees with status and mask");

    a_mask_read: assert property (@(posedge mclk) disable iff (!srst_n)
        (reg_rd && reg_addr == OFS_IRQ_MASK)
        |=> reg_rdata == DATA_W'($past(r.irq_mask)))
        else $error("irq mask misreported");

endmodule // bfwf_top

// ### bfwf_disp_model.sv
// display engine model: raises a flip request, later loads the new address
`timescale 1ns/100ps
module bfwf_disp_model (
    // control from the bench
    input  wire logic       mclk,
    input  wire logic       go,
    input  wire logic [1:0] idx,
    input  wire logic [4:0] dly,
    // flip status toward the block
    output logic      [2:0] flip_req,
    output logic      [2:0] flip_loaded,
    output logic            busy
);
    initial begin
        flip_req    = 3'h0;
        flip_loaded = 3'h0;
        busy        = 1'b0;
        forever begin
            @(posedge mclk);
            if (go) begin
                busy          <= 1'b1;
                flip_req[idx] <= 1'b1;
                repeat (dly) @(posedge mclk);
                flip_loaded[idx] <= 1'b1;
                // long hold so pending and stall have cleared before busy drops
                repeat (8) @(posedge mclk);
                flip_req[idx]    <= 1'b0;
                flip_loaded[idx] <= 1'b0;
                busy             <= 1'b0;
            end
        end
    end
endmodule // bfwf_disp_model

// ### blitter_flip_wait_flags_tb.sv
// self-checking bench for the blitter flip wait flags block
`timescale 1ns/100ps
module blitter_flip_wait_flags_tb;
    import bfwf_pkg::*;
    logic mclk, rst_n, reg_wr, reg_rd, go, parser_stall, irq, busy;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [2:0]  flip_req, flip_loaded;
    logic [14:0] cc;
    logic [1:0]  fidx;
    logic [4:0]  fdly;
    int err_total, tests_run, cyc, n, k, s;
    int seed = 32'h0337;

    bfwf_top bfwf_top_i (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flip_req(flip_req), .flip_loaded(flip_loaded),
        .execute_condition_code_register(cc), .parser_stall(parser_stall), .irq(irq));
    bfwf_disp_model bfwf_disp_model_i (.mclk(mclk), .go(go), .idx(fidx), .dly(fdly),
        .flip_req(flip_req), .flip_loaded(flip_loaded), .busy(busy));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask

    function automatic logic cc_exp(input int sel, input logic [14:0] v);
        return (sel >= 1 && sel <= 5) ? v[sel-1] : 1'b0;
    endfunction

    // i: 0 plane async (en 8, pend 11), 1 plane sync (7, 10), 2 sprite sync (6, 9)
    task automatic flip(input int i, input logic en);
        wr(OFS_FLAGS, en ? (32'h100 >> i) : 32'h0);
        @(posedge mclk);
        go   <= 1'b1;
        fidx <= i[1:0];
        fdly <= 5'd16 + 5'($random(seed) & 7);
        @(posedge mclk);
        go <= 1'b0;
        for (n = 0; n < 12 && parser_stall !== 1'b1; n++) @(negedge mclk);
        chk(parser_stall, en, "stall on flip");
        rd(OFS_FLAGS, d);
        chk(d[11-i], 1'b1, "pending flag");
        chk(parser_stall, en, "stall held until load");
        for (n = 0; n < 60 && busy !== 1'b0; n++) @(negedge mclk);
        chk(parser_stall, 1'b0, "stall released");
        rd(OFS_FLAGS, d);
        chk(d[11:9], 3'h0, "pending cleared");
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            report_and_stop;
        end
    end

    initial begin
        {rst_n, reg_wr, reg_rd, go, reg_addr, reg_wdata, cc, fidx, fdly} = '0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (3) @(posedge mclk);
        for (k = 0; k < 12; k += 4) begin
            rd(k[3:0], d);
            chk(d, 32'h0, "reset value");
        end
        rd(4'h2, d);
        chk(d, 32'h0, "unmapped read");
        wr(OFS_FLAGS, 32'hffff_ffff & ~32'h7);
        rd(OFS_FLAGS, d);
        chk(d, 32'h1c8, "reserved bit reads zero");
        $display("test registers done");
        wr(OFS_IRQ_MASK, 32'h7);
        rd(OFS_IRQ_STAT, d);
        for (k = 0; k < 6; k++) flip(k % 3, k < 3);
        $display("test flips done");
        wr(OFS_IRQ_MASK, 32'h0);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b0, "irq masked");
        wr(OFS_IRQ_MASK, 32'h7);
        repeat (2) @(negedge mclk);
        chk(irq, 1'b1, "irq unmasked");
        rd(OFS_IRQ_STAT, d);
        chk(d[2:0], 3'h7, "irq status");
        @(negedge mclk);
        chk(irq, 1'b0, "irq cleared by read");
        $display("test irq done");
        for (k = 0; k < 16; k++) begin
            s = k >> 1;
            wr(OFS_FLAGS, s);
            @(posedge mclk);
            cc <= 15'($random(seed)) | (s > 0 && k[0] ? 15'h1 << (s - 1) : 15'h0);
            repeat (3) @(negedge mclk);
            chk(parser_stall, cc_exp(s, cc), "cc wait");
            @(posedge mclk);
            cc <= 15'h0;
            repeat (3) @(negedge mclk);
            chk(parser_stall, 1'b0, "cc wait released");
        end
        $display("test cc done");
        report_and_stop;
    end
endmodule // blitter_flip_wait_flags_tb
